// ==== hw/fpl_host_ctrl.sv ====
// host controller driving the flash protection commands over the parallel bus
// Overview of operation
// - host waits two microseconds verify time after each password submission.
// - host selects password mode without first testing the password; only a password submission waits two microseconds.
// - host enters password command mode, then programs password.
// - host protects only target blocks before issuing irreversible lock.
// - boot-area program only with write-protect pin high.
`timescale 1ns/1ps
`include "fpl_consts.svh"
module fpl_host_ctrl
  import fpl_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic [31:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [31:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic [`FPL_ADDR_W-1:0]        flashAddr,
  output logic [`FPL_DATA_W-1:0]        flashDqOut,
  output logic                          flashDqOe,
  input  wire logic [`FPL_DATA_W-1:0]   flashDqIn,
  output logic                          flashCeN,
  output logic                          flashOeN,
  output logic                          flashWeN,
  output logic                          flashRstN,
  output logic                          flashWpN
);
  import fpl_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0]            ctrlReg, ctrlNext;
  logic [63:0]            pwdReg, pwdNext;
  logic [31:0]            blockReg, blockNext;
  logic [15:0]            resultReg, resultNext;
  logic                   refusedReg, refusedNext;
  logic                   pwdModeReg, pwdModeNext;
  logic                   irrLockReg, irrLockNext;
  logic                   globalReg, globalNext;
  logic                   awHeldReg, awHeldNext;
  logic                   wHeldReg, wHeldNext;
  logic [31:0]            awAddrReg, awAddrNext;
  logic [31:0]            wDataReg, wDataNext;
  logic                   bvalidReg, bvalidNext;
  logic [1:0]             brespReg, brespNext;
  logic                   rvalidReg, rvalidNext;
  logic [31:0]            rdataReg, rdataNext;
  logic [1:0]             rrespReg, rrespNext;
  fpl_state_t             stateReg, stateNext;
  fpl_op_t                opReg, opNext;
  logic [2:0]             stepReg, stepNext;
  logic [15:0]            cntReg, cntNext;
  logic [15:0]            dqSync1Reg, dqSync2Reg;
  logic                   goPulse;
  logic                   wrFire;
  logic [`FPL_ADDR_W-1:0] stepAddr;
  logic [`FPL_DATA_W-1:0] stepData;
  fpl_kind_t              stepKind;
  logic                   busy;

  assign busy = (stateReg != ST_IDLE);

  // ----------------------------------------------------------------
  // step table
  // ----------------------------------------------------------------
  fpl_seq_rom u_rom (
    .clk       (clk),
    .resetn    (resetn),
    .op        (opReg),
    .step      (stepReg),
    .pwd       (pwdReg),
    .blockWord (blockReg[31:16]),
    .blockAddr ({6'h00, blockReg[15:0]}),
    .stepAddr  (stepAddr),
    .stepData  (stepData),
    .stepKind  (stepKind)
  );

  // ----------------------------------------------------------------
  // axi-lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !awHeldReg && !bvalidReg;
  assign s_axi_wready  = !wHeldReg && !bvalidReg;
  assign s_axi_arready = !rvalidReg;
  assign s_axi_bvalid  = bvalidReg;
  assign s_axi_bresp   = brespReg;
  assign s_axi_rvalid  = rvalidReg;
  assign s_axi_rdata   = rdataReg;
  assign s_axi_rresp   = rrespReg;

  always_comb begin
    awHeldNext = awHeldReg;
    wHeldNext  = wHeldReg;
    awAddrNext = awAddrReg;
    wDataNext  = wDataReg;
    bvalidNext = bvalidReg;
    brespNext  = brespReg;
    rvalidNext = rvalidReg;
    rdataNext  = rdataReg;
    rrespNext  = rrespReg;
    ctrlNext   = ctrlReg;
    pwdNext    = pwdReg;
    blockNext  = blockReg;
    goPulse    = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeldNext = 1'b1;
      awAddrNext = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeldNext = 1'b1;
      wDataNext = s_axi_wdata;
    end
    wrFire = awHeldReg && wHeldReg;
    if (wrFire) begin
      awHeldNext = 1'b0;
      wHeldNext  = 1'b0;
      bvalidNext = 1'b1;
      brespNext  = 2'b00;
      unique case (awAddrReg[7:0])
        8'(`FPL_OFF_CTRL): begin
          ctrlNext = {22'h0, wDataReg[9:4], 4'h0};
          goPulse  = wDataReg[`FPL_CTRL_GO] && !busy;
        end
        8'(`FPL_OFF_PWD_LO): pwdNext[31:0]  = wDataReg;
        8'(`FPL_OFF_PWD_HI): pwdNext[63:32] = wDataReg;
        8'(`FPL_OFF_BLOCK):  blockNext      = wDataReg;
        default:             brespNext      = 2'b10;
      endcase
    end
    if (bvalidReg && s_axi_bready) begin
      bvalidNext = 1'b0;
    end
    if (rvalidReg && s_axi_rready) begin
      rvalidNext = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalidNext = 1'b1;
      rrespNext  = 2'b00;
      unique case (s_axi_araddr[7:0])
        8'(`FPL_OFF_CTRL):   rdataNext = ctrlReg;
        8'(`FPL_OFF_STATUS): rdataNext = {27'h0, globalReg, irrLockReg, pwdModeReg,
                                          refusedReg, busy};
        8'(`FPL_OFF_PWD_LO): rdataNext = pwdReg[31:0];
        8'(`FPL_OFF_PWD_HI): rdataNext = pwdReg[63:32];
        8'(`FPL_OFF_BLOCK):  rdataNext = blockReg;
        8'(`FPL_OFF_RESULT): rdataNext = {16'h0, resultReg};
        default: begin
          rdataNext = 32'h0000_0000;
          rrespNext = 2'b10;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_comb begin
    stateNext   = stateReg;
    opNext      = opReg;
    stepNext    = stepReg;
    cntNext     = cntReg;
    resultNext  = resultReg;
    refusedNext = refusedReg;
    pwdModeNext = pwdModeReg;
    irrLockNext = irrLockReg;
    globalNext  = globalReg;
    unique case (stateReg)
      ST_IDLE: begin
        if (goPulse) begin
          opNext      = fpl_op_t'(wDataReg[`FPL_CTRL_OP_LSB +: `FPL_CTRL_OP_W]);
          refusedNext = 1'b0;
          stepNext    = 3'd0;
          // skip what the device would ignore anyway
          if ((opNext == OP_IRR_LOCK) && (!globalReg || irrLockReg)) begin
            refusedNext = 1'b1;
          end else if (pwdModeReg && (opNext == OP_PWD_PROGRAM ||
                                      opNext == OP_PWD_READ)) begin
            refusedNext = 1'b1;
            resultNext  = 16'hFFFF;
          end else if (irrLockReg && (opNext == OP_NV_PROGRAM ||
                       opNext == OP_SET_LOCK || opNext == OP_PSR_PROGRAM ||
                       opNext == OP_PWD_SUBMIT)) begin
            refusedNext = 1'b1;
          end else if (opNext == OP_NV_PROGRAM && !globalReg) begin
            refusedNext = 1'b1;
          end else if (opNext == OP_BLK_WRITE && !wDataReg[`FPL_CTRL_WP] &&
                       blockReg[15]) begin
            refusedNext = 1'b1;
          end else begin
            stateNext = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        stateNext = (stepKind == KIND_END) ? ST_WAIT : (stepKind == KIND_READ) ? ST_READ : ST_WE;
        cntNext   = 16'h0000;
        if (stepKind == KIND_END) begin
          cntNext = (opReg == OP_PWD_SUBMIT) ? 16'(`FPL_TEST_WAIT_CYC) : 16'h0000;
        end
      end
      ST_WE: begin
        cntNext = cntReg + 16'h0001;
        if (cntReg == 16'(`FPL_WE_CYC - 1)) begin
          stepNext  = stepReg + 3'd1;
          stateNext = ST_DONE;
        end
      end
      ST_READ: begin
        cntNext = cntReg + 16'h0001;
        if (cntReg == 16'(`FPL_RD_CYC - 1)) begin
          resultNext = dqSync2Reg;
          stepNext   = stepReg + 3'd1;
          stateNext  = ST_DONE;
        end
      end
      ST_DONE: begin
        stateNext = ST_LOAD;
      end
      ST_WAIT: begin
        if (cntReg == 16'h0000) begin
          stateNext = ST_IDLE;
          stepNext  = 3'd0;
          unique case (opReg)
            OP_SET_LOCK:    globalNext = 1'b0;
            OP_PSR_PROGRAM: begin
              if (blockReg[16 + `FPL_PSR_PWD_BIT] == 1'b0 &&
                  blockReg[16 + `FPL_PSR_PT_BIT] == 1'b1) begin
                pwdModeNext = 1'b1;
              end
              if (pwdModeNext) begin
                globalNext = 1'b0;
              end
            end
            OP_LOCK_STATUS: globalNext = resultReg[0];
            OP_IRR_STATUS:  irrLockNext = !resultReg[0];
            OP_IRR_LOCK:    irrLockNext = 1'b1;
            default:        stateNext = ST_IDLE;
          endcase
        end else begin
          cntNext = cntReg - 16'h0001;
        end
      end
      default: stateNext = ST_IDLE;
    endcase
    if (!ctrlReg[`FPL_CTRL_RSTPIN] && !pwdModeReg) begin
      globalNext = 1'b1;
    end else if (!ctrlReg[`FPL_CTRL_RSTPIN]) begin
      globalNext = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flashAddr  <= `FPL_ADDR_W'(0);
      flashDqOut <= 16'h0000;
      flashDqOe  <= 1'b1;
      flashCeN   <= 1'b1;
      flashOeN   <= 1'b1;
      flashWeN   <= 1'b1;
      flashRstN  <= 1'b0;
      flashWpN   <= 1'b0;
    end else begin
      flashAddr  <= stepAddr;
      flashDqOut <= stepData;
      flashDqOe  <= !(stateNext == ST_WE);
      flashCeN   <= !(stateNext == ST_WE || stateNext == ST_READ);
      flashOeN   <= !(stateNext == ST_READ);
      flashWeN   <= !(stateNext == ST_WE && cntNext < 16'(`FPL_WE_CYC - 2));
      flashRstN  <= ctrlReg[`FPL_CTRL_RSTPIN];
      flashWpN   <= ctrlReg[`FPL_CTRL_WP];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dqSync1Reg <= 16'h0000;
      dqSync2Reg <= 16'h0000;
    end else begin
      dqSync1Reg <= flashDqIn;
      dqSync2Reg <= dqSync1Reg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrlReg    <= 32'h0000_0000;
      pwdReg     <= `FPL_PWD_FACTORY;
      blockReg   <= 32'h0000_0000;
      resultReg  <= 16'h0000;
      refusedReg <= 1'b0;
      pwdModeReg <= 1'b0;
      irrLockReg <= 1'b0;
      globalReg  <= 1'b0;
      awHeldReg  <= 1'b0;
      wHeldReg   <= 1'b0;
      awAddrReg  <= 32'h0000_0000;
      wDataReg   <= 32'h0000_0000;
      bvalidReg  <= 1'b0;
      brespReg   <= 2'b00;
      rvalidReg  <= 1'b0;
      rdataReg   <= 32'h0000_0000;
      rrespReg   <= 2'b00;
      stateReg   <= ST_IDLE;
      opReg      <= OP_LOCK_STATUS;
      stepReg    <= 3'd0;
      cntReg     <= 16'h0000;
    end else begin
      ctrlReg    <= ctrlNext;
      pwdReg     <= pwdNext;
      blockReg   <= blockNext;
      resultReg  <= resultNext;
      refusedReg <= refusedNext;
      pwdModeReg <= pwdModeNext;
      irrLockReg <= irrLockNext;
      globalReg  <= globalNext;
      awHeldReg  <= awHeldNext;
      wHeldReg   <= wHeldNext;
      awAddrReg  <= awAddrNext;
      wDataReg   <= wDataNext;
      bvalidReg  <= bvalidNext;
      brespReg   <= brespNext;
      rvalidReg  <= rvalidNext;
      rdataReg   <= rdataNext;
      rrespReg   <= rrespNext;
      stateReg   <= stateNext;
      opReg      <= opNext;
      stepReg    <= stepNext;
      cntReg     <= cntNext;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_irr_refused: assert property (@(posedge clk) disable iff (!resetn)
    (goPulse && stateReg == ST_IDLE && !globalReg &&
     wDataReg[7:4] == OP_IRR_LOCK) |=> (refusedReg && stateReg == ST_IDLE))
    else $error("irreversible lock issued with global lock clear");
  chk_pwd_blocked: assert property (@(posedge clk) disable iff (!resetn)
    (goPulse && stateReg == ST_IDLE && pwdModeReg && !irrLockReg &&
     wDataReg[7:4] == OP_PWD_READ) |=> (resultReg == 16'hFFFF && stateReg == ST_IDLE))
    else $error("password read reached the bus in password mode");
  chk_submit_wait: assert property (@(posedge clk) disable iff (!resetn)
    (stateReg == ST_LOAD && stepKind == KIND_END && opReg == OP_PWD_SUBMIT)
    |=> (stateReg == ST_WAIT && cntReg == 16'd200))
    else $error("submit verify wait not loaded");
  chk_irr_sticky: assert property (@(posedge clk) disable iff (!resetn)
    $rose(irrLockReg) |=> irrLockReg [*8])
    else $error("irreversible lock flag dropped");
  chk_wp_pin: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (flashWpN == $past(ctrlReg[9])))
    else $error("write protect pin not following control");
  chk_global_set: assert property (@(posedge clk) disable iff (!resetn)
    (stateReg == ST_WAIT && cntReg == 16'h0 && opReg == OP_SET_LOCK &&
     ctrlReg[8]) |=> !globalReg)
    else $error("global lock not cleared after set command");
  chk_nv_refused: assert property (@(posedge clk) disable iff (!resetn)
    (goPulse && stateReg == ST_IDLE && !globalReg && wDataReg[7:4] == OP_NV_PROGRAM)
    |=> stateReg == ST_IDLE)
    else $error("protection bit change sent with global lock clear");
  chk_we_pulse: assert property (@(posedge clk) disable iff (!resetn)
    $fell(flashWeN) |-> !flashDqOe && !flashCeN)
    else $error("write strobe without data drive");
endmodule

// ==== hw/fpl_consts.svh ====
// constants for the flash protection controller
`ifndef FPL_CONSTS_SVH
`define FPL_CONSTS_SVH
`define FPL_ADDR_W         22
`define FPL_DATA_W         16
`define FPL_OFF_CTRL       32'h0000_0000
`define FPL_OFF_STATUS     32'h0000_0004
`define FPL_OFF_PWD_LO     32'h0000_0008
`define FPL_OFF_PWD_HI     32'h0000_000C
`define FPL_OFF_BLOCK      32'h0000_0010
`define FPL_OFF_RESULT     32'h0000_0014
`define FPL_CTRL_GO        0
`define FPL_CTRL_OP_LSB    4
`define FPL_CTRL_OP_W      4
`define FPL_CTRL_RSTPIN    8
`define FPL_CTRL_WP        9
`define FPL_ST_BUSY        0
`define FPL_ST_REFUSED     1
`define FPL_ST_PWDMODE     2
`define FPL_ST_IRRLOCK     3
`define FPL_ST_GLOBAL      4
`define FPL_VERIFY_NS      1000
`define FPL_TEST_WAIT_NS   2000
`define FPL_CLK_NS         10
`define FPL_VERIFY_CYC     ((`FPL_VERIFY_NS + `FPL_CLK_NS - 1) / `FPL_CLK_NS)
`define FPL_TEST_WAIT_CYC  ((`FPL_TEST_WAIT_NS + `FPL_CLK_NS - 1) / `FPL_CLK_NS)
`define FPL_WE_CYC         8
`define FPL_RD_CYC         10
`define FPL_PSR_PWD_BIT    2
`define FPL_PSR_PT_BIT     1
`define FPL_ID_IRR_ADDR    22'h00_05FE
`define FPL_PWD_FACTORY    64'hFFFF_FFFF_FFFF_FFFF
`define FPL_SEQ_LEN        8
`endif

// ==== hw/fpl_pkg.sv ====
// types for the flash protection controller
package fpl_pkg;
  typedef enum logic [3:0] {
    OP_PWD_PROGRAM = 4'h1,
    OP_PWD_READ    = 4'h2,
    OP_PWD_SUBMIT  = 4'h3,
    OP_SET_LOCK    = 4'h4,
    OP_LOCK_STATUS = 4'h5,
    OP_PSR_PROGRAM = 4'h6,
    OP_PSR_READ    = 4'h7,
    OP_NV_PROGRAM  = 4'h8,
    OP_IRR_LOCK    = 4'h9,
    OP_IRR_STATUS  = 4'hA,
    OP_BLK_WRITE   = 4'hB
  } fpl_op_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_WE    = 3'b011,
    ST_READ  = 3'b010,
    ST_WAIT  = 3'b110,
    ST_DONE  = 3'b111
  } fpl_state_t;
  typedef enum logic [1:0] {
    KIND_WRITE = 2'b00,
    KIND_READ  = 2'b01,
    KIND_END   = 2'b10
  } fpl_kind_t;
endpackage

// ==== hw/fpl_seq_rom.sv ====
// command step table: address, data and kind per step
`timescale 1ns/1ps
`include "fpl_consts.svh"
module fpl_seq_rom
  import fpl_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire fpl_pkg::fpl_op_t         op,
  input  wire logic [2:0]               step,
  input  wire logic [63:0]              pwd,
  input  wire logic [15:0]              blockWord,
  input  wire logic [`FPL_ADDR_W-1:0]   blockAddr,
  output logic      [`FPL_ADDR_W-1:0]   stepAddr,
  output logic      [`FPL_DATA_W-1:0]   stepData,
  output fpl_pkg::fpl_kind_t            stepKind
);
  import fpl_pkg::*;

  logic [`FPL_ADDR_W-1:0] addrNext;
  logic [`FPL_DATA_W-1:0] dataNext;
  fpl_kind_t              kindNext;
  logic [1:0]             pwIdx;
  logic [15:0]            pwWord;

  always_comb begin
    pwIdx = 2'(step - 3'd3);
    pwWord = pwd[16*pwIdx +: 16];
    addrNext = `FPL_ADDR_W'(0);
    dataNext = 16'h0000;
    kindNext = KIND_END;
    if (step == 3'd0) begin
      addrNext = 22'h00_0555;
      dataNext = 16'h00AA;
      kindNext = KIND_WRITE;
    end else if (step == 3'd1) begin
      addrNext = 22'h00_02AA;
      dataNext = 16'h0055;
      kindNext = KIND_WRITE;
    end else begin
      unique case (op)
        OP_PWD_PROGRAM, OP_PWD_SUBMIT: begin
          // one word per section, address picks the section
          if (step == 3'd2) begin
            addrNext = 22'h00_0555;
            dataNext = (op == OP_PWD_SUBMIT) ? 16'h00A8 : 16'h00A0;
            kindNext = KIND_WRITE;
          end else if (step <= 3'd6) begin
            addrNext = `FPL_ADDR_W'(pwIdx);
            dataNext = pwWord;
            kindNext = KIND_WRITE;
          end
        end
        OP_PWD_READ, OP_LOCK_STATUS, OP_PSR_READ, OP_IRR_STATUS: begin
          if (step == 3'd2) begin
            addrNext = 22'h00_0555;
            dataNext = (op == OP_IRR_STATUS) ? 16'h0090 : 16'h00C0;
            kindNext = KIND_WRITE;
          end else if (step == 3'd3) begin
            addrNext = (op == OP_IRR_STATUS) ? `FPL_ID_IRR_ADDR : blockAddr;
            kindNext = KIND_READ;
          end
        end
        OP_SET_LOCK, OP_PSR_PROGRAM, OP_NV_PROGRAM, OP_IRR_LOCK, OP_BLK_WRITE: begin
          if (step == 3'd2) begin
            addrNext = 22'h00_0555;
            dataNext = (op == OP_IRR_LOCK) ? 16'h0060 : 16'h00A0;
            kindNext = KIND_WRITE;
          end else if (step == 3'd3) begin
            addrNext = blockAddr;
            dataNext = blockWord;
            kindNext = KIND_WRITE;
          end
        end
        default: begin
          kindNext = KIND_END;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stepAddr <= `FPL_ADDR_W'(0);
      stepData <= 16'h0000;
      stepKind <= KIND_END;
    end else begin
      stepAddr <= addrNext;
      stepData <= dataNext;
      stepKind <= kindNext;
    end
  end
endmodule

// ==== verification/fpl_flash_model.sv ====
// behavioural flash device seen from the controller's parallel bus
`timescale 1ns/1ps
module fpl_flash_model (
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        dqOe,
  output logic      [15:0] dqIn,
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        rstN,
  input  wire logic        wpN
);
  logic [15:0] pwd [4];
  logic [15:0] lastOut;
  logic [21:0] wrAddr [$];
  logic [15:0] wrData [$];
  realtime     lastWr;
  initial begin
    foreach (pwd[i]) pwd[i] = 16'hFFFF;
    lastOut = 16'h0000;
    lastWr = 0;
  end
  // ---------------------------------------------
  // write capture and read data
  // ---------------------------------------------
  always @(posedge weN) begin
    if (!ceN && rstN && !dqOe) begin
      wrAddr.push_back(addr);
      wrData.push_back(dq);
      lastWr = $realtime;
    end
  end
  always @(negedge oeN) lastOut = pwd[addr[1:0]];
  // released bus shows inverse of last value
  assign dqIn = (!ceN && !oeN && rstN) ? lastOut : ~lastOut;
endmodule

// ==== verification/test_flash_password_irreversible_lock.sv ====
// bench for the flash protection host controller
`timescale 1ns/1ps
module test_flash_password_irreversible_lock;
  import fpl_pkg::*;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, dqOe, ceN, oeN, weN, rstN, wpN;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0]  bresp, rresp;
  logic [21:0] fAddr;
  logic [15:0] dqOut, dqIn;
  int n_fail = 0, compares = 0;
  fpl_host_ctrl i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flashAddr(fAddr),
    .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqIn), .flashCeN(ceN), .flashOeN(oeN),
    .flashWeN(weN), .flashRstN(rstN), .flashWpN(wpN));
  fpl_flash_model i_flash (.addr(fAddr), .dq(dqOut), .dqOe(dqOe), .dqIn(dqIn), .ceN(ceN),
    .oeN(oeN), .weN(weN), .rstN(rstN), .wpN(wpN));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // runs one command and returns the status word once idle
  task automatic run(input logic [3:0] op, input logic wp, output logic [31:0] s);
    logic [1:0] r;
    axw(32'h0000_0000, {22'h00_0000, wp, 1'b1, op, 4'h1}, r);
    do axr(32'h0000_0004, s, r); while (s[0] !== 1'b0);
  endtask
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0]  r;
    axr(32'h0000_0040, d, r);
    check(d, 32'h0000_0000, "unmapped read data");
    check(r, 2'h2, "unmapped read response");
    axw(32'h0000_0044, 32'h0000_0001, r);
    check(r, 2'h2, "unmapped write");
    check(rstN, 1'b0, "reset pin idle");
    $display("test bus done");
  endtask
  task automatic t_submit;
    logic [31:0] s;
    logic [1:0]  r;
    int n;
    n = i_flash.wrAddr.size();
    axw(32'h0000_0008, 32'h1234_5678, r);
    axw(32'h0000_000C, 32'h9ABC_DEF0, r);
    run(OP_PWD_SUBMIT, 1'b1, s);
    check(s[4], 1'b1, "global lock after reset pin");
    check(i_flash.wrAddr.size() - n, 7, "submit write count");
    check(i_flash.wrAddr[n], 22'h00_0555, "unlock address");
    check(i_flash.wrData[n], 16'h00AA, "unlock data");
    for (int i = 0; i < 4; i++) begin
      check(i_flash.wrAddr[n + 3 + i], i, "word address");
      check(i_flash.wrData[n + 3 + i], 16'(64'h9ABC_DEF0_1234_5678 >> (16 * i)),
            "word data");
    end
    check($realtime - i_flash.lastWr >= 1000.0, 1, "verify wait");
    $display("test submit done");
  endtask
  task automatic t_refuse;
    logic [31:0] s;
    logic [1:0]  r;
    int n;
    run(OP_SET_LOCK, 1'b1, s);
    check(s[4], 1'b0, "global lock cleared");
    n = i_flash.wrAddr.size();
    run(OP_IRR_LOCK, 1'b1, s);
    check(s[1], 1'b1, "irreversible lock refused");
    run(OP_NV_PROGRAM, 1'b1, s);
    check(s[1], 1'b1, "protection bit refused");
    axw(32'h0000_0010, 32'h5A5A_8000, r);
    run(OP_BLK_WRITE, 1'b0, s);
    check(s[1], 1'b1, "boot write refused");
    check(i_flash.wrAddr.size(), n, "no bus cycles");
    run(OP_BLK_WRITE, 1'b1, s);
    check(s[1], 1'b0, "boot write allowed");
    run(OP_PWD_READ, 1'b1, s);
    axr(32'h0000_0014, s, r);
    check(s[15:0], 16'hFFFF, "factory password");
    axw(32'h0000_0010, 32'hFFFB_0000, r);
    run(OP_PSR_PROGRAM, 1'b1, s);
    check(s[2], 1'b1, "password mode selected");
    check(s[4], 1'b0, "global lock after settings program");
    run(OP_PWD_READ, 1'b1, s);
    check(s[1], 1'b1, "password read refused");
    axr(32'h0000_0014, s, r);
    check(s[15:0], 16'hFFFF, "password read all ones");
    $display("test refuse done");
  endtask
  initial begin
    resetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 32'h0000_0000; wdata = 32'h0000_0000; araddr = 32'h0000_0000;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_bus;
    t_submit;
    t_refuse;
    finish_test;
  end
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
endmodule
